// [srw_supervisor.sv]
// supervisory reset generator with manual reset and watchdog
// Notes on behaviour
// - low reset out on undervoltage, manual, expiry
// - high reset out mirrors, same hold time
// - reset held full timeout after cause clears
// - manual low holds reset, then timeout
// - untoggled kick input expires, one timeout reset
// - watchdog clears on reset, manual, edges
// - manual input reads as deasserted through reset, then follows the pin
// - watchdog held at zero during reset, restarts after
// - kick pulses of 150 ns accepted
`timescale 1ns/100ps
module srw_supervisor
    import srw_pkg::*;
#(
    parameter int unsigned RST_TIMEOUT_CYC = SRW_RST_TIMEOUT_CYC,
    parameter int unsigned WDT_TIMEOUT_CYC = SRW_WDT_TIMEOUT_CYC
) (
    input wire logic clk_sys_i,        // 10 MHz system clock
    input wire logic rst_i,            // sync reset, active high
    input wire logic ce_i,             // clock enable, freezes state when low
    input wire logic undervoltage_i,   // supply below threshold, async
    input wire logic manual_reset_n_i, // manual reset, active low, async
    input wire logic watchdog_kick_in_i, // watchdog kick level, async
    output logic reset_n_o,            // reset out, active low
    output logic reset_o               // reset out, active high
);
    // both timeouts must fit the counters
    if (RST_TIMEOUT_CYC < 1 || WDT_TIMEOUT_CYC < 2 ||
        longint'(RST_TIMEOUT_CYC) >= (longint'(1) << SRW_CNT_W) ||
        longint'(WDT_TIMEOUT_CYC) >= (longint'(1) << SRW_CNT_W)) begin : g_bad_timeout
        $error("srw_supervisor: timeout out of range");
    end

    typedef logic [SRW_CNT_W-1:0] srw_cnt_t;

    typedef enum logic {
        ST_RUN,
        ST_HOLD
    } srw_state_t;

    // true on the last count of a period
    function automatic logic cnt_last(input srw_cnt_t cnt, input int unsigned limit);
        srw_cnt_t last;
        last = srw_cnt_t'(limit - 1);
        return cnt == last;
    endfunction

    // next count, or zero on clear
    function automatic srw_cnt_t cnt_step(input srw_cnt_t cnt, input logic clear);
        srw_cnt_t nxt;
        nxt = cnt + srw_cnt_t'(1);
        if (clear) begin
            nxt = '0;
        end
        return nxt;
    endfunction

    logic uv_n_s;
    logic mr_n_s;
    logic kick_s;
    logic kick_prev_q;
    srw_state_t state_q;
    srw_state_t state_d;
    srw_cnt_t hold_q;
    srw_cnt_t hold_d;
    srw_cnt_t wdt_q;
    srw_cnt_t wdt_d;

    // undervoltage flag synchronised; reset value is inactive
    srw_sync u_uv (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .rst_val_i(1'b1),
        .d_i(~undervoltage_i),
        .q_o(uv_n_s)
    );

    // manual input held high through reset, then follows the pin
    srw_sync u_mr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .rst_val_i(1'b1),
        .d_i(manual_reset_n_i),
        .q_o(mr_n_s)
    );

    // one 100 ns sample catches a 150 ns pulse
    srw_sync u_wk (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .rst_val_i(1'b1),
        .d_i(watchdog_kick_in_i),
        .q_o(kick_s)
    );

    wire under_w = ~uv_n_s;
    wire manual_w = ~mr_n_s;
    wire in_reset_w = (state_q == ST_HOLD);

    // either edge on the kick input
    wire kick_edge_w = kick_s ^ kick_prev_q;

    // level held past the watchdog timeout
    wire wdt_last_w = cnt_last(wdt_q, WDT_TIMEOUT_CYC);
    wire wdt_hit_w = ~in_reset_w & wdt_last_w & ~kick_edge_w;

    wire cause_w = under_w | manual_w | wdt_hit_w;

    // last cycle of the hold period
    wire hold_done_w = cnt_last(hold_q, RST_TIMEOUT_CYC);

    // watchdog held at zero while reset stands
    wire wdt_clear_w = in_reset_w | cause_w | kick_edge_w;

    wire assert_next_w = (state_d == ST_HOLD);

    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        unique case (state_q)
            ST_RUN: begin
                if (cause_w) begin
                    state_d = ST_HOLD;
                    hold_d = '0;
                end
            end
            ST_HOLD: begin
                if (cause_w) begin
                    // restart hold while a cause stands
                    hold_d = '0;
                end else if (hold_done_w) begin
                    state_d = ST_RUN;
                    hold_d = '0;
                end else begin
                    hold_d = cnt_step(hold_q, 1'b0);
                end
            end
        endcase
    end

    // clear on reset, manual or edge
    assign wdt_d = cnt_step(wdt_q, wdt_clear_w);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= ST_HOLD;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hold_q <= '0;
        end else if (ce_i) begin
            hold_q <= hold_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wdt_q <= '0;
        end else if (ce_i) begin
            wdt_q <= wdt_d;
        end
    end

    // idle level of the kick sync, no false edge after reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            kick_prev_q <= 1'b1;
        end else if (ce_i) begin
            kick_prev_q <= kick_s;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reset_n_o <= ~SRW_RST_ASSERTED;
        end else if (ce_i) begin
            reset_n_o <= ~assert_next_w;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reset_o <= SRW_RST_ASSERTED;
        end else if (ce_i) begin
            reset_o <= assert_next_w;
        end
    end
endmodule

// [srw_pkg.sv]
// constants for the supervisory reset and watchdog block
package srw_pkg;
    localparam int unsigned SRW_CLK_HZ = 10000000;
    // least kick pulse width, nanoseconds
    localparam int unsigned SRW_MIN_KICK_NS = 150;
    localparam int unsigned SRW_CLK_NS = 1000000000 / SRW_CLK_HZ;
    // whole cycles in the least kick pulse, round down, at least one
    localparam int unsigned SRW_MIN_KICK_CYC =
        (SRW_MIN_KICK_NS / SRW_CLK_NS) < 1 ? 1 : (SRW_MIN_KICK_NS / SRW_CLK_NS);
    // default reset timeout and watchdog timeout in cycles
    localparam int unsigned SRW_RST_TIMEOUT_CYC = 1500000;
    localparam int unsigned SRW_WDT_TIMEOUT_CYC = 16000000;
    localparam int unsigned SRW_CNT_W = 32;
    localparam logic SRW_RST_ASSERTED = 1'b1;
    localparam logic [1:0] SRW_SYNC_RESET_VAL = 2'h3;
endpackage

// [srw_sync.sv]
// two-stage synchroniser for one pin level
`timescale 1ns/100ps
module srw_sync
    import srw_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic rst_i,     // sync reset, active high
    input wire logic ce_i,      // clock enable
    input wire logic rst_val_i, // level held through reset
    input wire logic d_i,       // async level in
    output logic q_o            // synchronised level
);
    logic meta_q;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_q <= rst_val_i;
            q_o <= rst_val_i;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// [srw_checker.sv]
// assertions on the supervisor pins
`timescale 1ns/100ps
module srw_checker
    import srw_pkg::*;
#(
    parameter int unsigned RST_TIMEOUT_CYC = SRW_RST_TIMEOUT_CYC,
    parameter int unsigned WDT_TIMEOUT_CYC = SRW_WDT_TIMEOUT_CYC
) (
    input wire logic clk_sys_i,          // clock
    input wire logic rst_i,              // sync reset
    input wire logic ce_i,               // clock enable
    input wire logic undervoltage_i,     // supply low
    input wire logic manual_reset_n_i,   // manual reset pin
    input wire logic watchdog_kick_in_i, // kick pin
    input wire logic reset_n_o,          // reset out, low
    input wire logic reset_o             // reset out, high
);
    logic [7:0] idle_q;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i || !ce_i);
    // cycles with reset off and kick level unchanged
    always_ff @(posedge clk_sys_i) begin
        idle_q <= (rst_i || reset_o || $changed(watchdog_kick_in_i)) ? 8'h00 : idle_q + 8'h01;
    end
    pair_inv_a: assert property (reset_o == !reset_n_o) else $error("out pair");
    uv_asserts_a: assert property (undervoltage_i |-> ##3 reset_o) else $error("uv");
    mr_asserts_a: assert property (!manual_reset_n_i |-> ##3 reset_o) else $error("mr");
    mr_hold_a: assert property ($rose(manual_reset_n_i) |-> ##2 reset_o[*8]) else $error("mh");
    uv_hold_a: assert property ($fell(undervoltage_i) |-> ##2 reset_o[*8]) else $error("uh");
    wdt_expire_a: assert property (idle_q <= WDT_TIMEOUT_CYC + 3) else $error("wdt");
    pulse_len_a: assert property ($rose(reset_o) |-> reset_o[*8]) else $error("len");
    no_early_a: assert property ($rose(reset_o) |-> $past(undervoltage_i, 3) ||
        !$past(manual_reset_n_i, 3) || $past(idle_q) >= WDT_TIMEOUT_CYC - 4) else $error("early");
    cover property ($rose(reset_o) && $past(idle_q) > 8'h08);
    cover property ($rose(manual_reset_n_i));
    cover property ($fell(undervoltage_i));
endmodule
bind srw_supervisor srw_checker #(.RST_TIMEOUT_CYC(RST_TIMEOUT_CYC),
    .WDT_TIMEOUT_CYC(WDT_TIMEOUT_CYC)) chk_u (.clk_sys_i, .rst_i, .ce_i, .undervoltage_i,
    .manual_reset_n_i, .watchdog_kick_in_i, .reset_n_o, .reset_o);

// [srw_cpu_model.sv]
// processor model that kicks the watchdog
`timescale 1ns/100ps
module srw_cpu_model (
    input wire logic clk_sys_i,   // clock
    input wire logic reset_n_i,   // reset from supervisor
    input wire logic run_i,       // kicking enabled
    input wire logic [7:0] gap_i, // cycles between toggles
    output logic kick_o = 1'b1    // kick level
);
    logic [7:0] cnt_q = 8'h00;
    // toggle in time, levels of gap_i + 1 cycles
    always @(posedge clk_sys_i) begin
        cnt_q <= (!reset_n_i || cnt_q >= gap_i) ? 8'h00 : cnt_q + 8'h01;
        if (reset_n_i && run_i && cnt_q >= gap_i) kick_o <= !kick_o;
    end
endmodule

// [tb_top.sv]
// self-checking bench for the supervisor
`timescale 1ns/100ps
module tb_top;
    localparam int RT = 8, WT = 20;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, uv = 1'b0, mr_en = 1'b0, run = 1'b1, kick, rn, ro;
    logic ce = 1'b1;
    logic [7:0] gap = 8'h04;
    int mismatches = 0, comparisons = 0, cyc = 0, n;
    tri1 mr_w;
    assign mr_w = mr_en ? 1'b0 : 1'bz;
    always #50 clk_sys_i = ~clk_sys_i;
    srw_supervisor #(.RST_TIMEOUT_CYC(RT), .WDT_TIMEOUT_CYC(WT)) dut_u (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .ce_i(ce), .undervoltage_i(uv), .manual_reset_n_i(mr_w),
        .watchdog_kick_in_i(kick), .reset_n_o(rn), .reset_o(ro));
    srw_cpu_model cpu_u (.clk_sys_i(clk_sys_i), .reset_n_i(rn), .run_i(run), .gap_i(gap),
        .kick_o(kick));
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic wait_ro(input logic v);
        for (n = 0; ro !== v && n < 300; n++) step(1);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(44));
        step(20);
        rst_i = 1'b0;
        step(1);
        chk(rn, 1'b0);
        wait_ro(1'b0);
        for (int i = 0; i < 8; i++) begin
            gap = 8'($urandom_range(1, 12));
            step(40);
            chk(ro, 1'b0);
        end
        run = 1'b0;
        wait_ro(1'b1);
        for (int i = 0; i < 2; i++) begin
            wait_ro(1'b0);
            chk(n inside {[RT : RT + 3]}, 1'b1);
            wait_ro(1'b1);
            chk(n inside {[WT - 1 : WT + 3]}, 1'b1);
        end
        run = 1'b1;
        wait_ro(1'b0);
        for (int i = 0; i < 6; i++) begin
            {uv, mr_en} = (i % 2) ? 2'h1 : 2'h2;
            step($urandom_range(3, 30));
            chk(ro, 1'b1);
            {uv, mr_en} = 2'h0;
            wait_ro(1'b0);
            chk(n inside {[RT + 2 : RT + 5]}, 1'b1);
            step(5);
        end
        uv = 1'b1;
        wait_ro(1'b1);
        {uv, ce} = 2'h0;
        step(30);
        chk(ro, 1'b1);
        ce = 1'b1;
        wait_ro(1'b0);
        chk(n inside {[RT + 2 : RT + 5]}, 1'b1);
        tally_and_finish();
    end
endmodule
